// ==== adc_channel_sequencer_tb_top.sv ====
// testbench: register-level tests of the converter sequencer
`timescale 1ns/1ps
`default_nettype none
module adc_channel_sequencer_tb_top;
	import adcs_pkg::*;
	localparam logic [DW-1:0] OFFS = 12'h0a5;
	localparam int SCH[4] = '{0, 2, 5, 7};
	localparam int SMP[4] = '{1, 1, 7, 3};
	logic pclk = 1'b0;
	logic presetn, psel, penable, pwrite, lp_sleep;
	logic [AW-1:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic pready, pslverr, irq, er, samp_q;
	logic sar_clk, sar_sample, sar_convert;
	logic [CHW-1:0] sar_mux;
	logic [DW-1:0] sar_result, code_e;
	logic [7:0] bad_cnt;
	int failures, samples_checked, cyc, first_act, last_act, slen;
	int mon_len[$];
	int mon_ch[$];

	always #2.5 pclk = ~pclk;

	adcs_top adcs_top_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .irq, .lp_sleep, .sar_clk, .sar_sample,
		.sar_convert, .sar_mux, .sar_result);
	adcs_sar_model adcs_sar_model_i (.pclk, .sar_clk, .sar_sample, .sar_convert,
		.sar_mux, .offs(OFFS), .sar_result, .bad_cnt);

	// ----------------------------------------
	// monitor of sample windows and activity span
	// ----------------------------------------
	always @(posedge pclk)
	begin
		cyc <= cyc + 1;
		samp_q <= sar_sample;
		if (sar_sample || sar_convert)
		begin
			if (first_act < 0)
				first_act <= cyc;
			last_act <= cyc;
		end
		if (sar_sample && !samp_q)
		begin
			mon_ch.push_back(int'(sar_mux));
			slen <= 1;
		end
		else if (sar_sample)
			slen <= slen + 1;
		if (!sar_sample && samp_q)
			mon_len.push_back(slen);
	end

	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task automatic results;
		if (failures == 0 && samples_checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : results

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			failures++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic xfer(input logic w, input logic [AW-1:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'b1 && n < 20);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 20)
		begin
			failures++;
			results();
		end
	endtask : xfer

	task automatic wr(input logic [AW-1:0] a, input logic [31:0] d);
		xfer(1'b1, a, d);
	endtask : wr

	task automatic rdchk(input logic [AW-1:0] a, input logic [31:0] exp);
		xfer(1'b0, a, 32'h0);
		chk(rd, exp);
	endtask : rdchk

	function automatic logic [AW-1:0] addr(input logic [AW-1:0] base, input int i);
		return base + AW'(4 * i);
	endfunction : addr

	// polling through the bus; a scan that never finishes ends the run
	task automatic wait_done;
		for (int n = 0; n < 1000; n++)
		begin
			xfer(1'b0, A_STS, 32'h0);
			if (rd[STS_DONE] === 1'b1)
				return;
		end
		failures++;
		results();
	endtask : wait_done

	task automatic wait_irq;
		for (int n = 0; n < 3000; n++)
		begin
			@(posedge pclk);
			if (irq === 1'b1)
				return;
		end
		failures++;
		results();
	endtask : wait_irq

	task automatic restart_mon;
		first_act = -1;
		mon_ch.delete();
		mon_len.delete();
	endtask : restart_mon

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial
	begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = '0;
		pwdata = '0;
		lp_sleep = 1'b0;
		failures = 0;
		samples_checked = 0;
		cyc = 0;
		first_act = -1;
		slen = 0;
		samp_q = 1'b0;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		rdchk(A_CTRL, 32'h0000_0002);
		rdchk(A_CHEN, 32'h0000_0001);
		rdchk(A_LIM, 32'h0fff_0000);
		rdchk(A_IEN, 32'h0);
		for (int i = 0; i < NCH; i++)
		begin
			rdchk(addr(A_SAMP, i), 32'h4);
			rdchk(addr(A_RES, i), 32'h0);
		end
		// status is read-only; an unmapped word answers with an error
		wr(A_STS, 32'hffff_ffff);
		rdchk(A_STS, 32'h0);
		wr(8'h1c, 32'hffff_ffff);
		chk(er, 32'h1);
		rdchk(8'h1c, 32'h0);
		chk(er, 32'h1);
		// hardware scan of four channels, one with a zero sample time
		wr(A_CHEN, 32'ha5);
		for (int i = 0; i < 4; i++)
			wr(addr(A_SAMP, SCH[i]), (i == 1) ? 32'h0 : 32'(SMP[i]));
		wr(A_LIM, 32'h0a00_0300);
		wr(A_IEN, 32'h2);
		wr(A_CTRL, 32'h3);
		restart_mon();
		wr(A_CMD, 32'h1);
		wait_irq();
		xfer(1'b0, A_STS, 32'h0);
		chk(rd & 32'h1, 32'h0);
		wait_done();
		chk(rd & 32'h3, 32'h3);
		chk(last_act - first_act + 1, 32'd1008);
		chk(mon_ch.size(), 32'd4);
		for (int i = 0; i < 4; i++)
		begin
			code_e = DW'(OFFS + DW'(SCH[i] * 512));
			chk(mon_ch[i], SCH[i]);
			chk(mon_len[i], SMP[i] * 12);
			rdchk(addr(A_RES, SCH[i]), {15'h0, (code_e < 12'h300 || code_e > 12'ha00),
				4'h0, code_e});
		end
		rdchk(addr(A_RES, 1), 32'h0);
		// interrupt raised, cleared, enabled and masked
		chk(irq, 32'h1);
		wr(A_CLR, 32'h2);
		repeat (2) @(posedge pclk);
		chk(irq, 32'h0);
		wr(A_IEN, 32'h3);
		repeat (2) @(posedge pclk);
		chk(irq, 32'h1);
		wr(A_IEN, 32'h2);
		repeat (2) @(posedge pclk);
		chk(irq, 32'h0);
		wr(A_CLR, 32'h1);
		xfer(1'b0, A_STS, 32'h0);
		chk(rd & 32'h3, 32'h0);
		// firmware-chosen channel three with its default sample time
		restart_mon();
		wr(A_CTRL, 32'h31);
		wr(A_CMD, 32'h1);
		wait_done();
		chk(mon_ch.size(), 32'd1);
		chk(mon_ch[0], 32'd3);
		chk(mon_len[0], 32'd48);
		rdchk(addr(A_RES, 3), 32'h0000_06a5);
		// continuous firmware conversions, halted and refused in retention mode
		wr(A_CLR, 32'h3);
		wr(A_CTRL, 32'h35);
		wr(A_CMD, 32'h1);
		wait_done();
		wr(A_CLR, 32'h1);
		wait_done();
		chk(mon_ch.size(), 32'd4);
		wr(A_CLR, 32'h3);
		lp_sleep <= 1'b1;
		wr(A_CMD, 32'h1);
		repeat (200) @(posedge pclk);
		chk(mon_ch.size(), 32'd4);
		xfer(1'b0, A_STS, 32'h0);
		chk(rd & 32'h31, 32'h0);
		lp_sleep <= 1'b0;
		repeat (300) @(posedge pclk);
		chk(mon_ch.size(), 32'd4);
		chk(bad_cnt, 32'h0);
		results();
	end
endmodule : adc_channel_sequencer_tb_top
`default_nettype wire

// ==== adcs_conv.sv ====
// module: converter clock divider, sample window and conversion timing
`timescale 1ns/1ps
`default_nettype none
module adcs_conv
	import adcs_pkg::*;
(
	input wire logic clk,
	input wire logic rstn,
	input wire logic run,
	adcs_conv_if.conv cif,
	output logic sar_clk,
	output logic sar_sample,
	output logic sar_convert,
	output logic [CHW-1:0] sar_mux,
	input wire logic [DW-1:0] sar_result
);
	localparam int DIVW = $clog2(SAR_DIV);
	localparam int CNTW = STW;
	localparam logic [DIVW-1:0] DIV_LAST = DIVW'(SAR_DIV - 1);
	localparam logic [DIVW-1:0] DIV_HALF = DIVW'(SAR_DIV / 2);
	localparam logic [CNTW-1:0] CONV_LOAD = CNTW'(CONV_CLKS);
	localparam logic [CNTW-1:0] CNT_ONE = 8'h01;
	localparam int CONV_PCLK = CONV_CLKS * SAR_DIV;

	adcs_cv_t state_q;
	logic [DIVW-1:0] div_q;
	logic [CNTW-1:0] cnt_q;
	logic [CHW-1:0] cur_q;
	logic [STW-1:0] nsamp_q;
	logic next_q;
	logic tick;

	// a zero sample time still gets one converter clock
	function automatic logic [CNTW-1:0] samp_len(input logic [STW-1:0] s);
		return (s == '0) ? CNT_ONE : s;
	endfunction : samp_len

	assign tick = (div_q == DIV_LAST);
	assign cif.busy = (state_q != CV_IDLE);

	// ----------------------------------------
	// converter clock
	// ----------------------------------------
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			div_q <= '0;
			sar_clk <= 1'b0;
		end
		else if (!run)
		begin
			// parked on the last count so the first high phase is full length
			div_q <= DIV_LAST;
			sar_clk <= 1'b0;
		end
		else
		begin
			div_q <= tick ? '0 : div_q + 1'b1; // R08
			sar_clk <= tick || (div_q < DIV_HALF - 1'b1);
		end
	end

	// ----------------------------------------
	// sample and convert sequence
	// ----------------------------------------
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			state_q <= CV_IDLE;
			cnt_q <= '0;
			cur_q <= '0;
			nsamp_q <= '0;
			next_q <= 1'b0;
			sar_mux <= '0;
			sar_sample <= 1'b0;
			sar_convert <= 1'b0;
			cif.job_take <= 1'b0;
			cif.res_valid <= 1'b0;
			cif.res_chan <= '0;
			cif.res_data <= '0;
		end
		else
		begin
			cif.job_take <= 1'b0;
			cif.res_valid <= 1'b0;
			if (!run) // R10
			begin
				state_q <= CV_IDLE;
				sar_sample <= 1'b0;
				sar_convert <= 1'b0;
				next_q <= 1'b0;
			end
			else if (tick)
			begin
				case (state_q)
					CV_IDLE:
					begin
						if (cif.job_valid)
						begin
							cif.job_take <= 1'b1;
							sar_mux <= cif.job_chan; // R01
							cnt_q <= samp_len(cif.job_samp); // R06
							sar_sample <= 1'b1;
							state_q <= CV_SAMPLE;
						end
					end
					CV_SAMPLE:
					begin
						if (cnt_q == CNT_ONE) // R09
						begin
							sar_sample <= 1'b0;
							sar_convert <= 1'b1;
							cnt_q <= CONV_LOAD;
							cur_q <= sar_mux;
							state_q <= CV_CONV;
							// the held input frees the mux: the next channel settles now
							next_q <= cif.job_valid; // R03
							if (cif.job_valid)
							begin
								cif.job_take <= 1'b1;
								sar_mux <= cif.job_chan;
								nsamp_q <= cif.job_samp;
							end
						end
						else
							cnt_q <= cnt_q - 1'b1;
					end
					CV_CONV:
					begin
						if (cnt_q == CNT_ONE) // R08
						begin
							sar_convert <= 1'b0;
							cif.res_valid <= 1'b1;
							cif.res_chan <= cur_q;
							cif.res_data <= sar_result;
							sar_sample <= next_q; // R03
							cnt_q <= samp_len(nsamp_q); // R06
							state_q <= next_q ? CV_SAMPLE : CV_IDLE;
						end
						else
							cnt_q <= cnt_q - 1'b1;
					end
					default:
						state_q <= CV_IDLE;
				endcase
			end
		end
	end

	conv_len_a: assert property (@(posedge clk) disable iff (!rstn || !run) // R08
		$rose(sar_convert) |-> ##CONV_PCLK cif.res_valid)
		else $error("conversion length wrong");
	sar_rate_a: assert property (@(posedge clk) disable iff (!rstn || !run) // R08
		$rose(sar_clk) |-> sar_clk[*6] ##1 !sar_clk)
		else $error("converter clock high phase wrong");
	no_gap_a: assert property (@(posedge clk) disable iff (!rstn || !run) // R03
		cif.res_valid && cif.busy |-> sar_sample)
		else $error("idle slot between conversions");
endmodule : adcs_conv
`default_nettype wire

// ==== adcs_conv_if.sv ====
// interface: job and result handshake between sequencer and converter timing
`timescale 1ns/1ps
`default_nettype none
interface adcs_conv_if;
	import adcs_pkg::*;
	logic job_valid;
	logic [CHW-1:0] job_chan;
	logic [STW-1:0] job_samp;
	logic job_take;
	logic res_valid;
	logic [CHW-1:0] res_chan;
	logic [DW-1:0] res_data;
	logic busy;
	modport seq (output job_valid, job_chan, job_samp,
		input job_take, res_valid, res_chan, res_data, busy);
	modport conv (input job_valid, job_chan, job_samp,
		output job_take, res_valid, res_chan, res_data, busy);
endinterface : adcs_conv_if
`default_nettype wire

// ==== adcs_limit.sv ====
// module: registered low/high range check of each new result
`timescale 1ns/1ps
`default_nettype none
module adcs_limit
	import adcs_pkg::*;
(
	input wire logic clk,
	input wire logic rstn,
	input wire logic in_valid,
	input wire logic [CHW-1:0] in_chan,
	input wire logic [DW-1:0] in_data,
	input wire logic [DW-1:0] lo,
	input wire logic [DW-1:0] hi,
	output logic out_valid,
	output logic [CHW-1:0] out_chan,
	output logic [DW-1:0] out_data,
	output logic out_oor
);
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			out_valid <= 1'b0;
			out_chan <= '0;
			out_data <= '0;
			out_oor <= 1'b0;
		end
		else
		begin
			out_valid <= in_valid;
			out_chan <= in_chan;
			out_data <= in_data;
			out_oor <= in_valid && ((in_data < lo) || (in_data > hi)); // R07
		end
	end
endmodule : adcs_limit
`default_nettype wire

// ==== adcs_pkg.sv ====
// package: constants and types of the adc channel sequencer
package adcs_pkg;
	localparam int NCH = 8;
	localparam int CHW = 3;
	localparam int DW = 12;
	localparam int STW = 8;
	localparam int AW = 8;
	// converter clock derived from pclk, rounded so it never exceeds the maximum
	localparam int PCLK_HZ = 200_000_000;
	localparam int SARCLK_MAX_HZ = 18_000_000;
	localparam int SAR_DIV = (PCLK_HZ + SARCLK_MAX_HZ - 1) / SARCLK_MAX_HZ;
	localparam int CONV_CLKS = 18;
	// register byte addresses
	localparam logic [AW-1:0] A_CTRL = 8'h00;
	localparam logic [AW-1:0] A_CMD = 8'h04;
	localparam logic [AW-1:0] A_CHEN = 8'h08;
	localparam logic [AW-1:0] A_STS = 8'h0c;
	localparam logic [AW-1:0] A_CLR = 8'h10;
	localparam logic [AW-1:0] A_IEN = 8'h14;
	localparam logic [AW-1:0] A_LIM = 8'h18;
	localparam logic [AW-1:0] A_SAMP = 8'h20;
	localparam logic [AW-1:0] A_RES = 8'h40;
	// field positions
	localparam int CTRL_EN = 0;
	localparam int CTRL_HW = 1;
	localparam int CTRL_CONT = 2;
	localparam int CTRL_FWCH = 4;
	localparam int CMD_START = 0;
	localparam int STS_DONE = 0;
	localparam int STS_RANGE = 1;
	localparam int STS_BUSY = 4;
	localparam int STS_RUN = 5;
	localparam int STS_CH = 8;
	localparam int LIM_HI = 16;
	localparam int RES_OOR = 16;
	localparam int NIRQ = 2;
	// reset values
	localparam logic CTRL_HW_RST = 1'b1;
	localparam logic [NCH-1:0] CHEN_RST = 8'h01;
	localparam logic [STW-1:0] SAMP_RST = 8'h04;
	localparam logic [DW-1:0] LIM_LO_RST = 12'h000;
	localparam logic [DW-1:0] LIM_HI_RST = 12'hfff;
	typedef enum logic [1:0] {
		CV_IDLE = 2'b00,
		CV_SAMPLE = 2'b01,
		CV_CONV = 2'b10
	} adcs_cv_t;
endpackage : adcs_pkg

// ==== adcs_sar_model.sv ====
// model of the analog converter core and its input multiplexer
`timescale 1ns/1ps
`default_nettype none
module adcs_sar_model (
	input wire logic pclk,
	input wire logic sar_clk,
	input wire logic sar_sample,
	input wire logic sar_convert,
	input wire logic [adcs_pkg::CHW-1:0] sar_mux,
	input wire logic [adcs_pkg::DW-1:0] offs,
	output logic [adcs_pkg::DW-1:0] sar_result,
	output logic [7:0] bad_cnt
);
	import adcs_pkg::*;
	logic [CHW-1:0] held_q = '0;
	logic sclk_q = 1'b0;
	logic conv_q = 1'b0;
	int conv_len = 0;
	int sclk_per = 0;
	int sclk_cnt = 0;
	initial
	begin
		sar_result = '0;
		bad_cnt = '0;
	end
	always @(posedge pclk)
	begin
		// the hold capacitor follows the selected input until sampling ends
		if (sar_sample)
			held_q <= sar_mux;
		// outside a conversion the line is not driven: never show a stale code
		sar_result <= sar_convert ? DW'(offs + {held_q, 9'h000}) : ~sar_result;
		sclk_q <= sar_clk;
		conv_q <= sar_convert;
		sclk_cnt <= sclk_cnt + 1;
		conv_len <= sar_convert ? conv_len + 1 : 0;
		if (sar_clk && !sclk_q)
		begin
			sclk_cnt <= 1;
			sclk_per <= sclk_cnt;
			// period below 1000/18 ns means the core is clocked above 18 MHz
			if (sclk_per > 0 && sclk_cnt * 90 < 1000)
				bad_cnt <= bad_cnt + 8'h01;
		end
		if (conv_q && !sar_convert && conv_len < 18 * sclk_per)
			bad_cnt <= bad_cnt + 8'h01;
	end
endmodule : adcs_sar_model
`default_nettype wire

// ==== adcs_top.sv ====
// module: apb-controlled eight-channel converter sequencer
// ----------------------------------------
// Notes on behaviour
// [R01] selects one of eight inputs for sampling
// [R02] hardware scan steps enabled channels itself
// [R03] next channel prepared during conversion, no gaps
// [R04] hardware sequence or firmware-chosen channel
// [R05] one result buffer per channel
// [R06] per-channel sample time applied when sampled
// [R07] out-of-range result raises interrupt immediately; here irq rises three pclk after the result
// [R08] eighteen converter clocks, at most 18 MHz
// [R09] sample window length is programmable
// [R10] no operation during low-power retention
// [R11] scan-complete flag after last channel buffered
// ----------------------------------------
`timescale 1ns/1ps
`default_nettype none
module adcs_top
	import adcs_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [adcs_pkg::AW-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic irq,
	input wire logic lp_sleep,
	output logic sar_clk,
	output logic sar_sample,
	output logic sar_convert,
	output logic [adcs_pkg::CHW-1:0] sar_mux,
	input wire logic [adcs_pkg::DW-1:0] sar_result
);
	import adcs_pkg::*;

	localparam int RGN = 3;

	adcs_conv_if cif();

	logic en_q;
	logic hw_q;
	logic cont_q;
	logic [CHW-1:0] fwch_q;
	logic [NCH-1:0] chen_q;
	logic [NIRQ-1:0] sts_q;
	logic [NIRQ-1:0] ien_q;
	logic [DW-1:0] lo_q;
	logic [DW-1:0] hi_q;
	logic [STW-1:0] samp_q [NCH];
	logic [DW-1:0] res_q [NCH];
	logic [NCH-1:0] oor_q;
	logic run_q;
	logic [CHW-1:0] cur_q;
	logic active;
	logic wr;
	logic start;
	logic [31:0] rd_d;
	logic [CHW:0] nxt;
	logic lim_valid;
	logic [CHW-1:0] lim_chan;
	logic [DW-1:0] lim_data;
	logic lim_oor;
	logic [NIRQ-1:0] sts_set;

	// nearest enabled channel after c, with a flag when the search wrapped
	function automatic logic [CHW:0] next_en(input logic [NCH-1:0] m,
		input logic [CHW-1:0] c);
		logic [CHW:0] r;
		logic [CHW-1:0] k;
		r = {1'b1, c};
		for (int i = NCH - 1; i >= 1; i--)
		begin
			k = c + CHW'(i);
			if (m[k])
				r = {(k <= c), k};
		end
		return r;
	endfunction : next_en

	function automatic logic [CHW-1:0] top_chan(input logic [NCH-1:0] m);
		logic [CHW-1:0] r;
		r = '0;
		for (int i = 0; i < NCH; i++)
			if (m[i])
				r = CHW'(i);
		return r;
	endfunction : top_chan

	function automatic logic map_hit(input logic [AW-1:0] a);
		return (a[AW-1:AW-RGN] == A_SAMP[AW-1:AW-RGN])
			|| (a[AW-1:AW-RGN] == A_RES[AW-1:AW-RGN])
			|| (a == A_CTRL) || (a == A_CMD) || (a == A_CHEN)
			|| (a == A_STS) || (a == A_CLR) || (a == A_IEN)
			|| (a == A_LIM);
	endfunction : map_hit

	// ----------------------------------------
	// apb slave
	// ----------------------------------------
	// one wait state: pready is a flop, so the access phase lasts two cycles
	assign wr = psel && penable && pready && pwrite && map_hit(paddr);
	assign start = wr && (paddr == A_CMD) && pwdata[CMD_START];

	always_comb
	begin
		rd_d = '0;
		if (paddr[AW-1:AW-RGN] == A_SAMP[AW-1:AW-RGN])
			rd_d[STW-1:0] = samp_q[paddr[CHW+1:2]];
		else if (paddr[AW-1:AW-RGN] == A_RES[AW-1:AW-RGN])
		begin
			rd_d[DW-1:0] = res_q[paddr[CHW+1:2]]; // R05
			rd_d[RES_OOR] = oor_q[paddr[CHW+1:2]];
		end
		else
		begin
			case (paddr)
				A_CTRL:
				begin
					rd_d[CTRL_EN] = en_q;
					rd_d[CTRL_HW] = hw_q;
					rd_d[CTRL_CONT] = cont_q;
					rd_d[CTRL_FWCH +: CHW] = fwch_q;
				end
				A_CHEN: rd_d[NCH-1:0] = chen_q;
				A_STS:
				begin
					rd_d[NIRQ-1:0] = sts_q;
					rd_d[STS_BUSY] = cif.busy;
					rd_d[STS_RUN] = run_q;
					rd_d[STS_CH +: CHW] = cur_q;
				end
				A_IEN: rd_d[NIRQ-1:0] = ien_q;
				A_LIM:
				begin
					rd_d[DW-1:0] = lo_q;
					rd_d[LIM_HI +: DW] = hi_q;
				end
				default: rd_d = '0;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= '0;
		end
		else
		begin
			pready <= psel && penable && !pready;
			pslverr <= psel && penable && !pready && !map_hit(paddr);
			prdata <= (psel && penable && !pready && !pwrite) ? rd_d : '0;
		end
	end

	// ----------------------------------------
	// control registers
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			en_q <= 1'b0;
			hw_q <= CTRL_HW_RST;
			cont_q <= 1'b0;
			fwch_q <= '0;
			chen_q <= CHEN_RST;
			ien_q <= '0;
			lo_q <= LIM_LO_RST;
			hi_q <= LIM_HI_RST;
			for (int i = 0; i < NCH; i++)
				samp_q[i] <= SAMP_RST;
		end
		else if (wr)
		begin
			case (paddr)
				A_CTRL:
				begin
					en_q <= pwdata[CTRL_EN];
					hw_q <= pwdata[CTRL_HW]; // R04
					cont_q <= pwdata[CTRL_CONT];
					fwch_q <= pwdata[CTRL_FWCH +: CHW];
				end
				A_CHEN: chen_q <= pwdata[NCH-1:0];
				A_IEN: ien_q <= pwdata[NIRQ-1:0];
				A_LIM:
				begin
					lo_q <= pwdata[DW-1:0];
					hi_q <= pwdata[LIM_HI +: DW];
				end
				default:
					if (paddr[AW-1:AW-RGN] == A_SAMP[AW-1:AW-RGN])
						samp_q[paddr[CHW+1:2]] <= pwdata[STW-1:0]; // R06
			endcase
		end
	end

	// ----------------------------------------
	// scan sequencing
	// ----------------------------------------
	// the converter takes a job only on a converter clock edge, which is
	// many pclk apart, so cur_q settles long before the next take
	assign active = en_q && !lp_sleep; // R10
	assign nxt = next_en(chen_q, cur_q);
	assign cif.job_valid = run_q;
	assign cif.job_chan = cur_q;
	assign cif.job_samp = samp_q[cur_q]; // R06

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			run_q <= 1'b0;
			cur_q <= '0;
		end
		else if (!active) // R10
			run_q <= 1'b0;
		else if (start && !run_q && (!hw_q || (chen_q != '0)))
		begin
			run_q <= 1'b1;
			cur_q <= hw_q ? CHW'(next_en(chen_q, CHW'(NCH - 1))) : fwch_q; // R04
		end
		else if (cif.job_take && run_q)
		begin
			if (hw_q)
			begin
				cur_q <= nxt[CHW-1:0]; // R02
				if (nxt[CHW] && !cont_q)
					run_q <= 1'b0;
			end
			else
			begin
				cur_q <= fwch_q; // R04
				if (!cont_q)
					run_q <= 1'b0;
			end
		end
	end

	adcs_conv u_conv (
		.clk(pclk),
		.rstn(presetn),
		.run(active),
		.cif(cif.conv),
		.sar_clk(sar_clk),
		.sar_sample(sar_sample),
		.sar_convert(sar_convert),
		.sar_mux(sar_mux), // R01
		.sar_result(sar_result)
	);

	adcs_limit u_limit (
		.clk(pclk),
		.rstn(presetn),
		.in_valid(cif.res_valid),
		.in_chan(cif.res_chan),
		.in_data(cif.res_data),
		.lo(lo_q),
		.hi(hi_q),
		.out_valid(lim_valid),
		.out_chan(lim_chan),
		.out_data(lim_data),
		.out_oor(lim_oor)
	);

	// ----------------------------------------
	// result buffers, status and interrupt
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			for (int i = 0; i < NCH; i++)
				res_q[i] <= '0;
			oor_q <= '0;
		end
		else if (lim_valid)
		begin
			res_q[lim_chan] <= lim_data; // R05
			oor_q[lim_chan] <= lim_oor;
		end
	end

	always_comb
	begin
		sts_set = '0;
		sts_set[STS_RANGE] = lim_valid && lim_oor; // R07
		sts_set[STS_DONE] = lim_valid && (!hw_q || (lim_chan == top_chan(chen_q))); // R11
	end

	// a set in the same cycle as a clear wins
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			sts_q <= '0;
		else if (wr && (paddr == A_CLR))
			sts_q <= sts_set | (sts_q & ~pwdata[NIRQ-1:0]);
		else
			sts_q <= sts_set | sts_q;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			irq <= 1'b0;
		else
			irq <= |(sts_q & ien_q); // R07
	end

	irq_lvl_a: assert property (@(posedge pclk) disable iff (!presetn) // R07
		(|(sts_q & ien_q)) |=> irq)
		else $error("irq low with enabled status");
	range_flag_a: assert property (@(posedge pclk) disable iff (!presetn) // R07
		lim_valid && lim_oor |=> sts_q[STS_RANGE])
		else $error("range flag not set");
	res_store_a: assert property (@(posedge pclk) disable iff (!presetn) // R05
		lim_valid |=> res_q[$past(lim_chan)] == $past(lim_data))
		else $error("result not buffered");
	apb_ready_a: assert property (@(posedge pclk) disable iff (!presetn)
		psel && penable && !pready |=> pready)
		else $error("apb answer late");
	sleep_stop_a: assert property (@(posedge pclk) disable iff (!presetn) // R10
		lp_sleep |=> !run_q && !sar_sample && !sar_convert)
		else $error("converter active in sleep");
	hw_step_a: assert property (@(posedge pclk) disable iff (!presetn) // R02
		cif.job_take && run_q && hw_q && active && !wr |=> chen_q[cur_q])
		else $error("scan stepped to disabled channel");
	done_cv: cover property (@(posedge pclk) disable iff (!presetn)
		hw_q && sts_set[STS_DONE]);
	range_cv: cover property (@(posedge pclk) disable iff (!presetn)
		sts_set[STS_RANGE]);
	fw_cv: cover property (@(posedge pclk) disable iff (!presetn)
		!hw_q && lim_valid);
endmodule : adcs_top
`default_nettype wire
